// File: logic/spc_config_bank.sv
// configuration register bank for the second serial port
// assumes a one-cycle strobe bus on core_clk; the port datapath sits
// outside and sends its busy, level-type and call line in here
`timescale 1ns/1ps

module spc_config_bank
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // global enables
    input wire logic global_config_one_en,
    input wire logic global_config_six_en,
    // port datapath status, from other clocking
    input wire logic port_busy,
    input wire logic port_level_irq,
    input wire logic incoming_call_line,
    input wire logic infrared_transmit_in,
    // port control
    output logic port_active,
    output logic port_clock_en,
    output logic port_outputs_default,
    output logic port_outputs_float,
    output logic extended_access_en,
    output logic call_line_irq_en,
    output logic infrared_transmit_out,
    output logic [15:0] port_base_addr,
    output logic [7:0] port_irq_number,
    output logic [7:0] port_rx_dma,
    output logic [7:0] port_tx_dma,
    // interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] sync1_q; // first stage, read only by second
    logic [3:0] sync2_q; // second stage
    logic busy_s, level_s, call_s, ir_tx_s;
    logic busy_prev_q; // for falling edge of busy
    logic call_prev_q; // for rising edge of call line

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end
        else
        begin
            sync1_q <= {infrared_transmit_in, incoming_call_line,
                        port_level_irq, port_busy};
            sync2_q <= sync1_q;
        end
    end

    assign busy_s = sync2_q[0];
    assign level_s = sync2_q[1];
    assign call_s = sync2_q[2];
    assign ir_tx_s = sync2_q[3];

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] activate_q; // activation
    logic [7:0] base_high_q; // base high, writable bits only
    logic [7:0] base_low_q; // base low, writable bits only
    logic [7:0] int_number_q; // irq number and wake enable
    logic int_type_q; // writable bit 1 of type
    logic [7:0] rx_dma_q; // receive channel
    logic [7:0] tx_dma_q; // transmit channel
    logic [7:0] config_q; // bits 7,1,0 stored, others zero
    logic [7:0] ev_status_q; // sticky events
    logic [7:0] ev_mask_q; // event enables

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire sel_act = reg_addr == spc_pkg::IDX_ACTIVATE;
    wire sel_bh = reg_addr == spc_pkg::IDX_BASE_HIGH;
    wire sel_bl = reg_addr == spc_pkg::IDX_BASE_LOW;
    wire sel_in = reg_addr == spc_pkg::IDX_INT_NUMBER;
    wire sel_it = reg_addr == spc_pkg::IDX_INT_TYPE;
    wire sel_rx = reg_addr == spc_pkg::IDX_RX_DMA;
    wire sel_tx = reg_addr == spc_pkg::IDX_TX_DMA;
    wire sel_cf = reg_addr == spc_pkg::IDX_PORT_CONFIG;
    wire sel_es = reg_addr == spc_pkg::IDX_EVENT_STATUS;
    wire sel_em = reg_addr == spc_pkg::IDX_EVENT_MASK;

    // logical device is live only with both global enables
    wire active_w = activate_q[0] & global_config_one_en
        & global_config_six_en;

    // read view of the config register, busy comes in live
    wire [7:0] config_view = {config_q[spc_pkg::CFG_BANK_BIT], 4'h0,
        busy_s, config_q[spc_pkg::CFG_POWER_BIT],
        config_q[spc_pkg::CFG_FLOAT_BIT]};

    // interrupt type: bit 0 follows the port's level mode
    wire [7:0] int_type_view = {6'h00, int_type_q, level_s};

    // read mux, unmapped index reads zero
    wire [7:0] rd_mux =
        sel_act ? activate_q :
        sel_bh ? (base_high_q & spc_pkg::MASK_BASE_HIGH) :
        sel_bl ? (base_low_q & spc_pkg::MASK_BASE_LOW) :
        sel_in ? int_number_q :
        sel_it ? int_type_view :
        sel_rx ? rx_dma_q :
        sel_tx ? tx_dma_q :
        sel_cf ? config_view :
        sel_es ? ev_status_q :
        sel_em ? ev_mask_q : 8'h00;

    // ------------------------------------------------------------
    // events
    // ------------------------------------------------------------
    wire ev_idle = busy_prev_q & ~busy_s;
    wire ev_call = call_s & ~call_prev_q;
    wire [7:0] ev_set = {6'h00, ev_call, ev_idle};
    wire [7:0] ev_clr = (reg_write & sel_es) ? reg_wdata : 8'h00;
    // a new event wins over a clear in the same cycle
    wire [7:0] ev_next = (ev_status_q & ~ev_clr) | ev_set;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            activate_q <= spc_pkg::RST_ACTIVATE;
            base_high_q <= spc_pkg::RST_BASE_HIGH;
            base_low_q <= spc_pkg::RST_BASE_LOW;
            int_number_q <= spc_pkg::RST_INT_NUMBER;
            int_type_q <= spc_pkg::RST_INT_TYPE[1];
            rx_dma_q <= spc_pkg::RST_DMA;
            tx_dma_q <= spc_pkg::RST_DMA;
            config_q <= spc_pkg::RST_PORT_CONFIG;
        end
        else if (reg_write)
        begin
            if (sel_act)
            begin
                activate_q <= reg_wdata;
            end
            if (sel_bh)
            begin
                base_high_q <= reg_wdata & spc_pkg::MASK_BASE_HIGH;
            end
            if (sel_bl)
            begin
                base_low_q <= reg_wdata & spc_pkg::MASK_BASE_LOW;
            end
            if (sel_in)
            begin
                int_number_q <= reg_wdata;
            end
            if (sel_it)
            begin
                int_type_q <= reg_wdata[1];
            end
            if (sel_rx)
            begin
                rx_dma_q <= reg_wdata;
            end
            if (sel_tx)
            begin
                tx_dma_q <= reg_wdata;
            end
            if (sel_cf)
            begin
                // busy and reserved bits never stored
                config_q <= reg_wdata & spc_pkg::MASK_CONFIG_WR;
            end
        end
    end

    // ------------------------------------------------------------
    // status, mask and edge history
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ev_status_q <= spc_pkg::RST_EVENTS;
            ev_mask_q <= spc_pkg::RST_EVENTS;
            busy_prev_q <= 1'b0;
            call_prev_q <= 1'b0;
        end
        else
        begin
            ev_status_q <= ev_next;
            if (reg_write & sel_em)
            begin
                ev_mask_q <= reg_wdata;
            end
            busy_prev_q <= busy_s;
            call_prev_q <= call_s;
        end
    end

    // ------------------------------------------------------------
    // output flops, every output straight from a register
    // ------------------------------------------------------------
    wire [7:0] cfg_next = (reg_write & sel_cf)
        ? (reg_wdata & spc_pkg::MASK_CONFIG_WR) : config_q;
    wire power_on = cfg_next[spc_pkg::CFG_POWER_BIT];
    // outputs are only floated while the device is inactive
    wire float_w = ~active_w & config_q[spc_pkg::CFG_FLOAT_BIT];

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            reg_rdata <= 8'h00;
            port_active <= 1'b0;
            port_clock_en <= 1'b0;
            port_outputs_default <= 1'b1;
            port_outputs_float <= 1'b0;
            extended_access_en <= 1'b0;
            call_line_irq_en <= 1'b0;
            infrared_transmit_out <= 1'b0;
            port_base_addr <= {spc_pkg::RST_BASE_HIGH,
                               spc_pkg::RST_BASE_LOW};
            port_irq_number <= spc_pkg::RST_INT_NUMBER;
            port_rx_dma <= spc_pkg::RST_DMA;
            port_tx_dma <= spc_pkg::RST_DMA;
            irq <= 1'b0;
        end
        else
        begin
            // read data valid only in the cycle after the strobe
            reg_rdata <= reg_read ? rd_mux : 8'h00;
            port_active <= active_w;
            // gated clock while active and bit 1 clear
            port_clock_en <= active_w & power_on;
            port_outputs_default <= ~(active_w & power_on);
            port_outputs_float <= float_w;
            // extended bank reachable only with bit 7 set
            extended_access_en <= active_w
                & config_q[spc_pkg::CFG_BANK_BIT];
            // call line stays armed in low power mode
            call_line_irq_en <= active_w;
            // transmit forced low when inactive, float bit ignored
            infrared_transmit_out <= active_w & power_on & ir_tx_s;
            port_base_addr <= {base_high_q & spc_pkg::MASK_BASE_HIGH,
                               base_low_q & spc_pkg::MASK_BASE_LOW};
            port_irq_number <= int_number_q;
            port_rx_dma <= rx_dma_q;
            port_tx_dma <= tx_dma_q;
            irq <= |(ev_next & ev_mask_q);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_activate_reset: assert property (@(posedge core_clk)
        $fell(reset) |-> activate_q == spc_pkg::RST_ACTIVATE)
        else $error("activate not reset");
    a_base_high_ro: assert property (@(posedge core_clk)
        disable iff (reset) reg_read && sel_bh |=> reg_rdata[7:3] == 5'h00)
        else $error("base high top bits not zero");
    a_base_low_ro: assert property (@(posedge core_clk)
        disable iff (reset) reg_read && sel_bl |=> reg_rdata[2:0] == 3'h0)
        else $error("base low bottom bits not zero");
    a_int_number_rw: assert property (@(posedge core_clk)
        disable iff (reset) reg_write && sel_in |=> ##1
        port_irq_number == $past(reg_wdata, 2))
        else $error("irq number write lost");
    a_int_type_ro: assert property (@(posedge core_clk)
        disable iff (reset) reg_read && sel_it |=> reg_rdata[7:2] == 6'h00)
        else $error("irq type high bits not zero");
    a_config_reset: assert property (@(posedge core_clk)
        $fell(reset) |-> config_q == spc_pkg::RST_PORT_CONFIG)
        else $error("config not reset");
    a_bank_gate: assert property (@(posedge core_clk)
        disable iff (reset) !config_q[7] |=> !extended_access_en)
        else $error("extended access with bank bit clear");
    a_busy_reads: assert property (@(posedge core_clk)
        disable iff (reset) reg_read && sel_cf
        |=> reg_rdata[2] == $past(busy_s))
        else $error("busy bit mismatch");
    a_clock_gate: assert property (@(posedge core_clk)
        disable iff (reset) active_w && !config_q[1] && !(reg_write && sel_cf)
        |=> !port_clock_en && port_outputs_default)
        else $error("clock not gated in low power");
    a_float_ctrl: assert property (@(posedge core_clk)
        disable iff (reset) active_w |=> !port_outputs_float)
        else $error("outputs floated while active");
    a_ir_tx_low: assert property (@(posedge core_clk)
        disable iff (reset) !active_w |=> !infrared_transmit_out)
        else $error("infrared transmit high while inactive");
    a_reserved_zero: assert property (@(posedge core_clk)
        disable iff (reset) reg_read && sel_cf |=> reg_rdata[6:3] == 4'h0)
        else $error("reserved bits not zero");

    // ------------------------------------------------------------
    // checks on stored fields, copies, power and events
    // ------------------------------------------------------------
    // stored fields take exactly what software may change
    a_activate_rw: assert property (@(posedge core_clk)
        disable iff (reset) reg_write && sel_act
        |=> activate_q == $past(reg_wdata))
        else $error("activation write lost");
    a_base_high_wr: assert property (@(posedge core_clk)
        disable iff (reset) reg_write && sel_bh
        |=> base_high_q[7:3] == 5'h00)
        else $error("base high top bits stored");
    a_base_low_wr: assert property (@(posedge core_clk)
        disable iff (reset) reg_write && sel_bl
        |=> base_low_q[2:0] == 3'h0)
        else $error("base low bottom bits stored");
    a_int_type_wr: assert property (@(posedge core_clk)
        disable iff (reset) reg_write && sel_it
        |=> int_type_q == $past(reg_wdata[1]))
        else $error("irq type bit 1 write lost");
    a_config_ro: assert property (@(posedge core_clk)
        disable iff (reset) reg_write && sel_cf
        |=> config_q[6:2] == 5'h00)
        else $error("busy or reserved bits stored");

    // copies to the port land two edges after the write
    a_base_out: assert property (@(posedge core_clk)
        disable iff (reset)
        port_base_addr[15:11] == 5'h00 && port_base_addr[2:0] == 3'h0)
        else $error("base address alignment broken");
    a_rx_dma_copy: assert property (@(posedge core_clk)
        disable iff (reset) reg_write && sel_rx |=> ##1
        port_rx_dma == $past(reg_wdata, 2))
        else $error("receive dma copy wrong");
    a_tx_dma_copy: assert property (@(posedge core_clk)
        disable iff (reset) reg_write && sel_tx |=> ##1
        port_tx_dma == $past(reg_wdata, 2))
        else $error("transmit dma copy wrong");

    // low power keeps the registers and the call line armed
    a_power_keep: assert property (@(posedge core_clk)
        disable iff (reset) active_w && !config_q[1] && !reg_write
        |=> $stable(rx_dma_q) && $stable(int_number_q))
        else $error("register lost in low power");
    a_call_armed: assert property (@(posedge core_clk)
        disable iff (reset) active_w
        |=> call_line_irq_en)
        else $error("call line not armed while active");
    a_clock_on: assert property (@(posedge core_clk)
        disable iff (reset) active_w && power_on
        |=> port_clock_en && !port_outputs_default)
        else $error("port clock off in normal power");
    a_float_on: assert property (@(posedge core_clk)
        disable iff (reset) !active_w && config_q[0]
        |=> port_outputs_float)
        else $error("outputs not floated while inactive");

    // a call line edge is kept even against a clear
    a_call_event: assert property (@(posedge core_clk)
        disable iff (reset) ev_call
        |=> ev_status_q[1])
        else $error("call line event lost");
    a_call_irq: assert property (@(posedge core_clk)
        disable iff (reset) ev_status_q[1] && ev_mask_q[1] && !reg_write
        |=> irq)
        else $error("call line interrupt missing");

endmodule : spc_config_bank

// File: logic/spc_pkg.sv
// constants for the second serial port configuration bank
// assumes an 8-bit indexed configuration port on core_clk
package spc_pkg;

    // ------------------------------------------------------------
    // register indexes
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
    localparam logic [7:0] IDX_BASE_LOW = 8'h61;
    localparam logic [7:0] IDX_INT_NUMBER = 8'h70;
    localparam logic [7:0] IDX_INT_TYPE = 8'h71;
    localparam logic [7:0] IDX_RX_DMA = 8'h74;
    localparam logic [7:0] IDX_TX_DMA = 8'h75;
    localparam logic [7:0] IDX_PORT_CONFIG = 8'hf0;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'hf8;
    localparam logic [7:0] IDX_EVENT_MASK = 8'hf9;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ACTIVATE = 8'h00;
    localparam logic [7:0] RST_BASE_HIGH = 8'h02;
    localparam logic [7:0] RST_BASE_LOW = 8'hf8;
    localparam logic [7:0] RST_INT_NUMBER = 8'h03;
    localparam logic [7:0] RST_INT_TYPE = 8'h03;
    localparam logic [7:0] RST_DMA = 8'h04;
    localparam logic [7:0] RST_PORT_CONFIG = 8'h02;
    localparam logic [7:0] RST_EVENTS = 8'h00;

    // ------------------------------------------------------------
    // field masks and positions
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_BASE_HIGH = 8'h07;
    localparam logic [7:0] MASK_BASE_LOW = 8'hf8;
    localparam logic [7:0] MASK_INT_TYPE_WR = 8'h02;
    localparam logic [7:0] MASK_CONFIG_WR = 8'h83;
    localparam int CFG_BANK_BIT = 7;
    localparam int CFG_BUSY_BIT = 2;
    localparam int CFG_POWER_BIT = 1;
    localparam int CFG_FLOAT_BIT = 0;
    localparam int INT_TYPE_LEVEL_BIT = 0;
    // event bits: busy fell, incoming call line edge
    localparam int EV_IDLE_BIT = 0;
    localparam int EV_CALL_BIT = 1;
    localparam int EV_WIDTH = 2;

endpackage : spc_pkg

// File: test/spc_port_model.sv
// stand-in for the serial port datapath beside the config bank
// assumes the bench states its wishes on core_clk rising edges
`timescale 1ns/1ps

module spc_port_model
(
    // clock
    input wire logic core_clk,
    // wishes: busy, level type, call line, infrared in
    input wire logic [3:0] want,
    // levels seen by the bank
    output logic port_busy,
    output logic port_level_irq,
    output logic incoming_call_line,
    output logic infrared_transmit_in
);
    // ------------------------------------------------------------
    // levels move 2 ns after the edge
    // ------------------------------------------------------------
    // the skew keeps them off the bank's sampling edge, like real pins
    // levels are unknown until the first edge; the bank's reset hides it
    always @(posedge core_clk)
    begin
        {port_busy, port_level_irq, incoming_call_line,
            infrared_transmit_in} <= #2 want;
    end
endmodule : spc_port_model

// File: test/tb_top.sv
// self-checking bench for the second serial port config bank
// assumes the bank and a port model, one 200 MHz clock
`timescale 1ns/1ps

module tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic core_clk, reset, reg_write, reg_read, g1, g6, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic port_busy, port_level_irq, incoming_call_line, ir_in;
    logic port_active, port_clock_en, outs_dflt, outs_float, ext_en;
    logic call_en, ir_out;
    logic [15:0] base;
    logic [7:0] irq_num, rx_dma, tx_dma;
    logic [3:0] want; // busy, level type, call line, infrared in
    int fail_count, samples_checked;
    int mdl [256]; // expected register contents
    int wm [256]; // writable bits per index
    logic [7:0] idx [10];

    spc_config_bank spc_config_bank_i (.core_clk(core_clk),
        .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .global_config_one_en(g1),
        .global_config_six_en(g6), .port_busy(port_busy),
        .port_level_irq(port_level_irq),
        .incoming_call_line(incoming_call_line),
        .infrared_transmit_in(ir_in), .port_active(port_active),
        .port_clock_en(port_clock_en), .port_outputs_default(outs_dflt),
        .port_outputs_float(outs_float), .extended_access_en(ext_en),
        .call_line_irq_en(call_en), .infrared_transmit_out(ir_out),
        .port_base_addr(base), .port_irq_number(irq_num),
        .port_rx_dma(rx_dma), .port_tx_dma(tx_dma), .irq(irq));
    spc_port_model spc_port_model_i (.core_clk(core_clk), .want(want),
        .port_busy(port_busy), .port_level_irq(port_level_irq),
        .incoming_call_line(incoming_call_line),
        .infrared_transmit_in(ir_in));

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fail_count++; // a hang counts as a mismatch
        final_report();
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one-cycle write, then the model follows
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
        if (a == spc_pkg::IDX_EVENT_STATUS)
            mdl[a] &= ~int'(d);
        else
            mdl[a] = (mdl[a] & ~wm[a]) | (int'(d) & wm[a]);
    endtask : wr
    // read, compare the one cycle of data against the model
    task automatic rdc(input logic [7:0] a);
        int e;
        e = mdl[a];
        if (a == spc_pkg::IDX_PORT_CONFIG)
            e |= int'(want[3]) << 2;
        if (a == spc_pkg::IDX_INT_TYPE)
            e |= int'(want[2]);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 chk({8'h00, reg_rdata}, e[15:0]);
    endtask : rdc
    // let synchronisers and derived outputs land
    task automatic settle();
        repeat (5) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic setw(input logic [3:0] v);
        @(posedge core_clk);
        want <= v;
        settle();
    endtask : setw
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {reset, g1, g6, reg_write, reg_read} = 5'h1c;
        {reg_addr, reg_wdata, want} = 20'h00004; // level type high
        idx = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75,
            8'hf0, 8'hf9, 8'h33};
        foreach (idx[i]) wm[idx[i]] = 8'hff;
        // the event mask keeps its whole byte
        wm[8'h60] = 8'h07;
        wm[8'h61] = 8'hf8;
        wm[8'h71] = 8'h02;
        wm[8'hf0] = 8'h83;
        wm[8'h33] = 8'h00;
        mdl[8'h60] = 8'h02;
        mdl[8'h61] = 8'hf8;
        mdl[8'h70] = 8'h03;
        mdl[8'h71] = 8'h02;
        mdl[8'h74] = 8'h04;
        mdl[8'h75] = 8'h04;
        mdl[8'hf0] = 8'h02;
        void'($urandom(32'hc75603ad));
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        foreach (idx[i]) rdc(idx[i]);
        // random values through every index but event status, unmapped one included
        for (int r = 0; r < 3; r++)
        begin
            foreach (idx[i]) wr(idx[i], 8'($urandom));
            // level type input toggles so bit 0 of 71h reads both ways
            setw({1'b0, r[0], 2'h0});
            foreach (idx[i]) rdc(idx[i]);
        end
        settle();
        chk(base, 16'((mdl[8'h60] << 8) | mdl[8'h61]));
        chk({8'h00, irq_num}, 16'(mdl[8'h70]));
        chk({8'h00, rx_dma}, 16'(mdl[8'h74]));
        chk({8'h00, tx_dma}, 16'(mdl[8'h75]));
        // activation needs both global enables
        wr(8'hf9, 8'h00);
        wr(8'h30, 8'h01);
        wr(8'hf0, 8'h02);
        setw(4'h5);
        chk({port_active, port_clock_en}, 16'h3);
        chk({outs_dflt, ir_out}, 16'h1);
        @(posedge core_clk);
        g6 <= 1'b0;
        settle();
        chk({port_active, ir_out, outs_float}, 16'h0);
        @(posedge core_clk);
        g6 <= 1'b1;
        // low power keeps registers, blocks clock, keeps call line
        wr(8'hf0, 8'h80);
        settle();
        chk({ext_en, port_clock_en, outs_dflt}, 16'h5);
        chk({15'h0, call_en}, 16'h1);
        rdc(8'h74);
        wr(8'hf0, 8'h02);
        settle();
        chk({ext_en, port_clock_en, outs_dflt}, 16'h2);
        // inactive: float only with bit 0, infrared out always low
        wr(8'h30, 8'h00);
        settle();
        chk({outs_float, ir_out}, 16'h0);
        wr(8'hf0, 8'h01);
        settle();
        chk({outs_float, ir_out}, 16'h2);
        wr(8'h30, 8'h01);
        wr(8'hf9, 8'h03);
        settle();
        chk({outs_float, irq}, 16'h0);
        // busy shows live, its end raises an event
        setw(4'hc);
        rdc(8'hf0);
        setw(4'h4);
        mdl[8'hf8] = 8'h01;
        rdc(8'hf8);
        chk({15'h0, irq}, 16'h1);
        wr(8'hf8, 8'h01);
        settle();
        chk({15'h0, irq}, 16'h0);
        // call line edge in low power still interrupts
        wr(8'hf0, 8'h00);
        setw(4'h6);
        mdl[8'hf8] = 8'h02;
        rdc(8'hf8);
        chk({call_en, irq}, 16'h3);
        wr(8'hf9, 8'h00);
        settle();
        chk({15'h0, irq}, 16'h0);
        wr(8'hf8, 8'h03);
        rdc(8'hf8);
        final_report();
    end
endmodule : tb_top
